//--- eov_pkg.sv
// constants and types for the oam pdu validation stage
// Operation
// RULE_01: separate_level_flag set means every frame of the flow is data.
// RULE_02: transmit lookup reads frame_kind_field; only y1731 pdus get transmit checks.
// RULE_03: transmit discard bumps transmit_discard_counter, sets flag, optional error copy.
// RULE_04: one continuity-only selector gates error flags and copies in both directions.
// RULE_05: transmit pdu passing checks is marked valid and forwarded.
// RULE_06: receive lookup checks frame kind; only y1731 pdus get receive checks.
// RULE_07: level above engine level: drop if drop_above_level, else treat as data.
// RULE_08: continuity pdu with zero period is illegal and dropped before level checks; code tests it after the above-level check, before the below-level check.
// RULE_09: zero_period_last kept per ccm; change sets zero_period_flag; optional copy.
// RULE_10: level equal to engine level proceeds to destination mac check.
// RULE_11: level below engine level is blocked and sets low_level_block_flag.
// RULE_12: low_level_last kept per ccm; change flag; optional copy; level_drop_counter.
// RULE_13: dest mac checked per dest_mac_check_select; failure blocks, flags, copies.
// RULE_14: no version check for link trace, generic and unknown pdus.
// RULE_15: version_check_enable compares version to per-kind accepted set.
// RULE_16: unaccepted version blocks pdu, sets version_error_flag, optional copy.
// RULE_17: after version pass dispatch continuity, synthetic loss, or valid others.
// RULE_18: group_id_check_enable compares received 48-byte group id to configured one.
// RULE_19: group_id_last kept; change sets flag; interrupt only if enabled.
// RULE_20: group id failure drops, counts in group_id_error_counter, optional copy.
// RULE_21: endpoint_id_check_enable compares endpoint id to remote_endpoint_identifier.
// RULE_22: endpoint_id_last kept; change sets flag; interrupt only if enabled.
// RULE_23: endpoint id failure drops, counts in its error counter, optional copy.
// RULE_24: continuity pdu passing both id checks is valid and forwarded.
// RULE_25: flags stick until software writes one; interrupt when flag and enable set; code interrupts only on the four last-result change flags.
package eov_pkg;
	localparam logic [6:0] A_CTRL = 7'h00;
	localparam logic [6:0] A_EXTR = 7'h04;
	localparam logic [6:0] A_IENA = 7'h08;
	localparam logic [6:0] A_STKY = 7'h0c;
	localparam logic [6:0] A_LAST = 7'h10;
	localparam logic [6:0] A_VERS = 7'h14;
	localparam logic [6:0] A_PEER = 7'h18;
	localparam logic [6:0] A_TXDC = 7'h1c;
	localparam logic [6:0] A_LVDC = 7'h20;
	localparam logic [6:0] A_GIDC = 7'h24;
	localparam logic [6:0] A_EIDC = 7'h28;
	localparam logic [6:0] A_GID = 7'h40;
	localparam int GID_WORDS = 12;
	localparam int C_DROP = 3;
	localparam int C_DMAC = 4;
	localparam int C_VERS = 6;
	localparam int C_CONT = 7;
	localparam int C_GIDEN = 8;
	localparam int C_EIDEN = 9;
	localparam int C_CCMEN = 10;
	localparam int S_TX = 0;
	localparam int S_ZERO = 1;
	localparam int S_LOWCHG = 2;
	localparam int S_LOWBLK = 3;
	localparam int S_DMAC = 4;
	localparam int S_VERS = 5;
	localparam int S_GID = 6;
	localparam int S_EID = 7;
	localparam int E_TX = 0;
	localparam int E_ZERO = 1;
	localparam int E_LOW = 2;
	localparam int E_DMAC = 3;
	localparam int E_VERS = 4;
	localparam int E_GID = 5;
	localparam int E_EID = 6;
	localparam int L_ZERO = 0;
	localparam int L_LOW = 1;
	localparam int L_GID = 2;
	localparam int L_EID = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] VERS_RST = 32'h1111_1111;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [2:0] {
		CLS_CCM = 3'h0, CLS_CCMLM = 3'h1, CLS_LT = 3'h2, CLS_GEN = 3'h3,
		CLS_UNK = 3'h4, CLS_SYN = 3'h5, CLS_OTHER = 3'h6
	} eov_cls_t;
	typedef enum logic [1:0] {
		DM_NONE = 2'h0, DM_UC = 2'h1, DM_MC = 2'h2, DM_ANY = 2'h3
	} eov_dmac_t;
	typedef enum logic [1:0] {
		V_DATA = 2'h0, V_OAM = 2'h1, V_DROP = 2'h2, V_SYN = 2'h3
	} eov_verdict_t;
	typedef struct packed {
		logic valid;
		logic is_tx;
		logic sep_level;
		logic is_y1731;
		eov_cls_t cls;
		logic [2:0] level;
		logic period_zero;
		logic dmac_uc_ok;
		logic dmac_mc_ok;
		logic [1:0] version;
		logic [12:0] mep_id;
		logic [383:0] group_id;
	} eov_frame_t;
	typedef struct packed {
		logic valid;
		eov_verdict_t verdict;
		logic copy_err;
	} eov_result_t;
endpackage

//--- eov_validate.sv
// oam pdu validation stage with axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module eov_validate (
	input wire logic aclk,
	input wire logic aresetn,
	input wire eov_pkg::eov_frame_t frame_i,
	output var eov_pkg::eov_result_t result_o,
	output logic irq_o,
	input wire logic [6:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [6:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import eov_pkg::*;

	// ************************************
	// state
	// ************************************
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] extr_reg, extr_next;
	logic [31:0] iena_reg, iena_next;
	logic [31:0] stky_reg, stky_next;
	logic [3:0] last_reg, last_next;
	logic [31:0] vers_reg, vers_next;
	logic [12:0] peer_reg, peer_next;
	logic [31:0] txdc_reg, txdc_next;
	logic [31:0] lvdc_reg, lvdc_next;
	logic [31:0] gidc_reg, gidc_next;
	logic [31:0] eidc_reg, eidc_next;
	logic [31:0] gid_reg [GID_WORDS];
	logic [31:0] gid_next [GID_WORDS];
	logic [383:0] gid_flat;
	eov_result_t res_reg, res_next;
	logic irq_reg, irq_next;
	logic awr_reg, awr_next;
	logic bv_reg, bv_next;
	logic [1:0] br_reg, br_next;
	logic arr_reg, arr_next;
	logic rv_reg, rv_next;
	logic [1:0] rr_reg, rr_next;
	logic [31:0] rd_reg, rd_next;

	genvar gi;
	generate
		for (gi = 0; gi < GID_WORDS; gi++) begin : g_gid
			assign gid_flat[gi*32 +: 32] = gid_reg[gi];
		end
	endgenerate

	// ************************************
	// register bus
	// ************************************
	logic wr_go, rd_go;
	logic [31:0] wmask;
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bv_reg & ~awr_reg;
	assign rd_go = s_axi_arvalid & ~rv_reg & ~arr_reg;
	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// ************************************
	// validation
	// ************************************
	logic is_ccm, gate, lvl_hi, lvl_lo, dmac_ok, vers_ok;
	logic [31:0] set_s, clr_s;
	logic [4:0] vidx;
	always_comb begin
		is_ccm = (frame_i.cls == CLS_CCM) | (frame_i.cls == CLS_CCMLM);
		// error flags and copies restricted to continuity pdus when ctrl_reg[C_CONT] is set
		gate = ~ctrl_reg[C_CONT] | is_ccm; // [RULE_04]
		lvl_hi = frame_i.level > ctrl_reg[2:0];
		lvl_lo = frame_i.level < ctrl_reg[2:0];
		case (eov_dmac_t'(ctrl_reg[C_DMAC +: 2]))
			DM_NONE: dmac_ok = 1'b1;
			DM_UC: dmac_ok = frame_i.dmac_uc_ok;
			DM_MC: dmac_ok = frame_i.dmac_mc_ok;
			DM_ANY: dmac_ok = frame_i.dmac_uc_ok | frame_i.dmac_mc_ok;
			default: dmac_ok = 1'b0;
		endcase
		vidx = 5'({frame_i.cls, 2'h0}) + 5'(frame_i.version);
		vers_ok = ~ctrl_reg[C_VERS] | vers_reg[vidx]; // [RULE_15]
		if (frame_i.cls == CLS_LT || frame_i.cls == CLS_GEN ||
			frame_i.cls == CLS_UNK) begin
			vers_ok = 1'b1; // [RULE_14]
		end
		set_s = 32'h0;
		res_next = '{valid: frame_i.valid, verdict: V_DATA, copy_err: 1'b0};
		last_next = last_reg;
		txdc_next = txdc_reg;
		lvdc_next = lvdc_reg;
		gidc_next = gidc_reg;
		eidc_next = eidc_reg;
		if (!frame_i.valid || frame_i.sep_level) begin
			res_next.verdict = V_DATA; // [RULE_01]
		end else if (frame_i.is_tx) begin
			if (!frame_i.is_y1731) begin
				res_next.verdict = V_DATA; // [RULE_02]
			end else if (lvl_lo) begin
				res_next.verdict = V_DROP;
				txdc_next = txdc_reg + 32'h1; // [RULE_03]
				set_s[S_TX] = gate; // [RULE_03]
				res_next.copy_err = gate & extr_reg[E_TX]; // [RULE_03]
			end else begin
				res_next.verdict = V_OAM; // [RULE_05]
			end
		end else if (!frame_i.is_y1731) begin
			res_next.verdict = V_DATA; // [RULE_06]
		end else if (lvl_hi) begin
			res_next.verdict = ctrl_reg[C_DROP] ? V_DROP : V_DATA; // [RULE_07]
		end else begin
			if (is_ccm) begin
				last_next[L_ZERO] = frame_i.period_zero; // [RULE_09]
			end
			if (is_ccm && frame_i.period_zero) begin
				res_next.verdict = V_DROP; // [RULE_08]
				res_next.copy_err = gate & extr_reg[E_ZERO]; // [RULE_09]
			end else begin
				if (is_ccm) begin
					last_next[L_LOW] = lvl_lo; // [RULE_12]
				end
				if (lvl_lo) begin
					res_next.verdict = V_DROP; // [RULE_11]
					set_s[S_LOWBLK] = gate; // [RULE_11]
					res_next.copy_err = gate & extr_reg[E_LOW]; // [RULE_12]
					if (is_ccm) begin
						lvdc_next = lvdc_reg + 32'h1; // [RULE_12]
					end
				end else if (!dmac_ok) begin
					res_next.verdict = V_DROP; // [RULE_10] [RULE_13]
					set_s[S_DMAC] = gate; // [RULE_13]
					res_next.copy_err = gate & extr_reg[E_DMAC]; // [RULE_13]
				end else if (!vers_ok) begin
					res_next.verdict = V_DROP; // [RULE_16]
					set_s[S_VERS] = gate; // [RULE_16]
					res_next.copy_err = gate & extr_reg[E_VERS]; // [RULE_16]
				end else if (frame_i.cls == CLS_SYN) begin
					res_next.verdict = V_SYN; // [RULE_17]
				end else if (!is_ccm || !ctrl_reg[C_CCMEN]) begin
					res_next.verdict = V_OAM; // [RULE_17]
				end else if (ctrl_reg[C_GIDEN] &&
					frame_i.group_id != gid_flat) begin
					last_next[L_GID] = 1'b1; // [RULE_18] [RULE_19]
					res_next.verdict = V_DROP; // [RULE_20]
					gidc_next = gidc_reg + 32'h1; // [RULE_20]
					res_next.copy_err = extr_reg[E_GID]; // [RULE_20]
				end else begin
					last_next[L_GID] = 1'b0; // [RULE_19]
					if (ctrl_reg[C_EIDEN] && frame_i.mep_id != peer_reg) begin
						last_next[L_EID] = 1'b1; // [RULE_21] [RULE_22]
						res_next.verdict = V_DROP; // [RULE_23]
						eidc_next = eidc_reg + 32'h1; // [RULE_23]
						res_next.copy_err = extr_reg[E_EID]; // [RULE_23]
					end else begin
						last_next[L_EID] = 1'b0; // [RULE_22]
						res_next.verdict = V_OAM; // [RULE_24]
					end
				end
			end
		end
		// change of a last result raises its flag
		set_s[S_ZERO] = last_next[L_ZERO] ^ last_reg[L_ZERO]; // [RULE_09]
		set_s[S_LOWCHG] = last_next[L_LOW] ^ last_reg[L_LOW]; // [RULE_12]
		set_s[S_GID] = last_next[L_GID] ^ last_reg[L_GID]; // [RULE_19]
		set_s[S_EID] = last_next[L_EID] ^ last_reg[L_EID]; // [RULE_22]

		// bus side
		ctrl_next = ctrl_reg;
		extr_next = extr_reg;
		iena_next = iena_reg;
		vers_next = vers_reg;
		peer_next = peer_reg;
		gid_next = gid_reg;
		clr_s = 32'h0;
		awr_next = wr_go;
		bv_next = (bv_reg & ~s_axi_bready) | awr_reg;
		br_next = br_reg;
		if (wr_go) begin
			br_next = RESP_OK;
			case (s_axi_awaddr)
				A_CTRL: ctrl_next = merge(ctrl_reg, s_axi_wdata, wmask);
				A_EXTR: extr_next = merge(extr_reg, s_axi_wdata, wmask);
				A_IENA: iena_next = merge(iena_reg, s_axi_wdata, wmask);
				A_STKY: clr_s = s_axi_wdata & wmask; // [RULE_25]
				A_VERS: vers_next = merge(vers_reg, s_axi_wdata, wmask);
				A_PEER: peer_next = 13'(merge({19'h0, peer_reg},
					s_axi_wdata, wmask));
				A_LAST, A_TXDC, A_LVDC, A_GIDC, A_EIDC: br_next = RESP_OK;
				default: begin
					if (s_axi_awaddr[6] && s_axi_awaddr[5:2] < 4'hc) begin
						gid_next[s_axi_awaddr[5:2]] = merge(
							gid_reg[s_axi_awaddr[5:2]], s_axi_wdata, wmask);
					end else begin
						br_next = RESP_ERR;
					end
				end
			endcase
		end
		// a set in the same cycle as a clear wins
		stky_next = (stky_reg & ~clr_s) | set_s; // [RULE_25]
		irq_next = |({stky_reg[S_EID], stky_reg[S_GID], stky_reg[S_LOWCHG],
			stky_reg[S_ZERO]} & iena_reg[3:0]); // [RULE_25]
		arr_next = rd_go;
		rv_next = (rv_reg & ~s_axi_rready) | arr_reg;
		rr_next = rr_reg;
		rd_next = rd_reg;
		if (rd_go) begin
			rr_next = RESP_OK;
			case (s_axi_araddr)
				A_CTRL: rd_next = ctrl_reg;
				A_EXTR: rd_next = extr_reg;
				A_IENA: rd_next = iena_reg;
				A_STKY: rd_next = stky_reg;
				A_LAST: rd_next = {28'h0, last_reg};
				A_VERS: rd_next = vers_reg;
				A_PEER: rd_next = {19'h0, peer_reg};
				A_TXDC: rd_next = txdc_reg;
				A_LVDC: rd_next = lvdc_reg;
				A_GIDC: rd_next = gidc_reg;
				A_EIDC: rd_next = eidc_reg;
				default: begin
					if (s_axi_araddr[6] && s_axi_araddr[5:2] < 4'hc) begin
						rd_next = gid_reg[s_axi_araddr[5:2]];
					end else begin
						rd_next = 32'h0;
						rr_next = RESP_ERR;
					end
				end
			endcase
		end
	end

	// ************************************
	// registers
	// ************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RST;
			extr_reg <= 32'h0;
			iena_reg <= 32'h0;
			stky_reg <= 32'h0;
			last_reg <= 4'h0;
			vers_reg <= VERS_RST;
			peer_reg <= 13'h0;
			txdc_reg <= 32'h0;
			lvdc_reg <= 32'h0;
			gidc_reg <= 32'h0;
			eidc_reg <= 32'h0;
			for (int i = 0; i < GID_WORDS; i++) begin
				gid_reg[i] <= 32'h0;
			end
			res_reg <= '0;
			irq_reg <= 1'b0;
			awr_reg <= 1'b0;
			bv_reg <= 1'b0;
			br_reg <= RESP_OK;
			arr_reg <= 1'b0;
			rv_reg <= 1'b0;
			rr_reg <= RESP_OK;
			rd_reg <= 32'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			extr_reg <= extr_next;
			iena_reg <= iena_next;
			stky_reg <= stky_next;
			last_reg <= last_next;
			vers_reg <= vers_next;
			peer_reg <= peer_next;
			txdc_reg <= txdc_next;
			lvdc_reg <= lvdc_next;
			gidc_reg <= gidc_next;
			eidc_reg <= eidc_next;
			gid_reg <= gid_next;
			res_reg <= res_next;
			irq_reg <= irq_next;
			awr_reg <= awr_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
			arr_reg <= arr_next;
			rv_reg <= rv_next;
			rr_reg <= rr_next;
			rd_reg <= rd_next;
		end
	end

	assign result_o = res_reg;
	assign irq_o = irq_reg;
	assign s_axi_awready = awr_reg;
	assign s_axi_wready = awr_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = br_reg;
	assign s_axi_arready = arr_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rresp = rr_reg;
	assign s_axi_rdata = rd_reg;

	// ************************************
	// checks
	// ************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sep_data_a: assert property ( // [RULE_01]
		frame_i.valid && frame_i.sep_level |=>
		result_o.valid && result_o.verdict == V_DATA && !result_o.copy_err)
		else $error("separate level frame not passed as data");
	tx_discard_a: assert property ( // [RULE_03]
		frame_i.valid && frame_i.is_tx && !frame_i.sep_level &&
		frame_i.is_y1731 && lvl_lo |=>
		result_o.verdict == V_DROP && txdc_reg == $past(txdc_reg) + 32'h1)
		else $error("transmit discard not counted");
	tx_valid_a: assert property ( // [RULE_05]
		frame_i.valid && frame_i.is_tx && !frame_i.sep_level &&
		frame_i.is_y1731 && !lvl_lo |=> result_o.verdict == V_OAM)
		else $error("transmit pdu not marked valid");
	rx_nony_a: assert property ( // [RULE_06]
		frame_i.valid && !frame_i.is_tx && !frame_i.is_y1731 |=>
		result_o.verdict == V_DATA)
		else $error("non y1731 receive frame not data");
	high_level_a: assert property ( // [RULE_07]
		frame_i.valid && !frame_i.is_tx && !frame_i.sep_level &&
		frame_i.is_y1731 && lvl_hi |=>
		result_o.verdict == ($past(ctrl_reg[C_DROP]) ? V_DROP : V_DATA))
		else $error("high level handling wrong");
	low_block_a: assert property ( // [RULE_11]
		frame_i.valid && !frame_i.is_tx && !frame_i.sep_level &&
		frame_i.is_y1731 && lvl_lo && !frame_i.period_zero && gate |=>
		result_o.verdict == V_DROP && stky_reg[S_LOWBLK])
		else $error("low level pdu not blocked");
	sticky_hold_a: assert property ( // [RULE_25]
		stky_reg[S_DMAC] && !(wr_go && s_axi_awaddr == A_STKY)
		|=> stky_reg[S_DMAC])
		else $error("sticky bit lost without clear");
	irq_follow_a: assert property ( // [RULE_25]
		stky_reg[S_GID] && iena_reg[L_GID] |=> irq_o)
		else $error("interrupt not raised");
	gid_count_a: assert property ( // [RULE_20]
		frame_i.valid && !frame_i.is_tx && !frame_i.sep_level &&
		frame_i.is_y1731 && is_ccm && !lvl_hi && !lvl_lo &&
		!frame_i.period_zero && dmac_ok && vers_ok &&
		ctrl_reg[C_CCMEN] && ctrl_reg[C_GIDEN] &&
		frame_i.group_id != gid_flat |=>
		gidc_reg == $past(gidc_reg) + 32'h1 && result_o.verdict == V_DROP)
		else $error("group id error not counted");
	bus_resp_a: assert property (
		wr_go |=> s_axi_awready ##1 s_axi_bvalid)
		else $error("write response late");

	tx_drop_c: cover property (result_o.valid && result_o.copy_err);
	ccm_ok_c: cover property (result_o.valid && result_o.verdict == V_OAM);
	syn_c: cover property (result_o.verdict == V_SYN);
endmodule
`default_nettype wire

//--- eov_frame_src.sv
// frame descriptor source standing in for the pipeline lookups
`timescale 1ns/10ps
`default_nettype none
module eov_frame_src (
	input wire logic aclk,
	output var eov_pkg::eov_frame_t frame_o
);
	import eov_pkg::*;
	// ****************************************
	// descriptor drive
	// ****************************************
	initial frame_o = '0;
	// valid stands one cycle, then payload is scrambled, never left stale
	task automatic send(input eov_frame_t f);
		@(posedge aclk);
		frame_o <= f;
		@(posedge aclk);
		frame_o <= {1'h0, ~f[$bits(eov_frame_t)-2:0]};
	endtask
endmodule
`default_nettype wire

//--- eov_tb.sv
// self-checking testbench for the oam pdu validation stage
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import eov_pkg::*;
	logic aclk, aresetn, irq;
	eov_frame_t frame;
	eov_result_t res;
	logic [6:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, r;
	int n_fail, check_count;
	eov_frame_src src (.aclk(aclk), .frame_o(frame));
	eov_validate uut (.aclk(aclk), .aresetn(aresetn), .frame_i(frame),
		.result_o(res), .irq_o(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] v);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'h0;
		if (i == 64) begin
			n_fail++;
			finish_test();
		end
	endtask
	task automatic rd(input logic [6:0] a);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'h0;
		if (i == 64) begin
			n_fail++;
			finish_test();
		end
	endtask
	task automatic rb(input logic [6:0] a, input int b, input logic e);
		rd(a);
		chk(d[b], e);
	endtask
	function automatic eov_frame_t mk(input logic tx, input eov_cls_t c,
		input logic [2:0] l);
		eov_frame_t f;
		f = '0;
		f.valid = 1'h1;
		f.is_tx = tx;
		f.is_y1731 = 1'h1;
		f.cls = c;
		f.level = l;
		f.dmac_uc_ok = 1'h1;
		f.dmac_mc_ok = 1'h1;
		return f;
	endfunction
	// result stands in the cycle after the taking edge
	task automatic fr(input eov_frame_t f, input eov_verdict_t v, input logic c);
		src.send(f);
		#1;
		chk({res.valid, res.verdict, res.copy_err}, {1'h1, v, c});
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		chk({res.valid, irq}, 32'h0);
		rd(A_CTRL);
		chk(d, CTRL_RST);
		chk(r, RESP_OK);
		rd(A_VERS);
		chk(d, VERS_RST);
		rd(7'h30);
		chk(r, RESP_ERR);
		chk(d, 32'h0);
		wr(7'h30, 32'h0);
		chk(r, RESP_ERR);
		wstrb <= 4'h1;
		wr(A_PEER, 32'h1fff);
		chk(r, RESP_OK);
		wstrb <= 4'hf;
		rd(A_PEER);
		chk(d, 32'hff);
	endtask
	task automatic t_bypass;
		eov_frame_t f;
		wr(A_CTRL, 32'h3);
		f = mk(1'h0, CLS_CCM, 3'h1);
		f.sep_level = 1'h1;
		fr(f, V_DATA, 1'h0);
		f = mk(1'h1, CLS_OTHER, 3'h1);
		f.is_y1731 = 1'h0;
		fr(f, V_DATA, 1'h0);
		f.is_tx = 1'h0;
		fr(f, V_DATA, 1'h0);
		rd(A_STKY);
		chk(d, 32'h0);
		rd(A_LVDC);
		chk(d, 32'h0);
	endtask
	task automatic t_tx;
		wr(A_EXTR, 32'h1);
		fr(mk(1'h1, CLS_OTHER, 3'h2), V_DROP, 1'h1);
		fr(mk(1'h1, CLS_OTHER, 3'h3), V_OAM, 1'h0);
		rd(A_TXDC);
		chk(d, 32'h1);
		rb(A_STKY, S_TX, 1'h1);
		wr(A_STKY, 32'h1);
		rb(A_STKY, S_TX, 1'h0);
		wr(A_CTRL, 32'h83);
		fr(mk(1'h1, CLS_OTHER, 3'h0), V_DROP, 1'h0);
		rb(A_STKY, S_TX, 1'h0);
		fr(mk(1'h1, CLS_CCMLM, 3'h0), V_DROP, 1'h1);
		rb(A_STKY, S_TX, 1'h1);
		rd(A_TXDC);
		chk(d, 32'h3);
	endtask
	task automatic t_level;
		eov_frame_t f;
		wr(A_CTRL, 32'h403);
		wr(A_EXTR, 32'h6);
		wr(A_IENA, 32'h1);
		fr(mk(1'h0, CLS_OTHER, 3'h5), V_DATA, 1'h0);
		wr(A_CTRL, 32'h40b);
		fr(mk(1'h0, CLS_OTHER, 3'h5), V_DROP, 1'h0);
		fr(mk(1'h0, CLS_CCM, 3'h1), V_DROP, 1'h1);
		rb(A_STKY, S_LOWBLK, 1'h1);
		rb(A_STKY, S_LOWCHG, 1'h1);
		rb(A_LAST, L_LOW, 1'h1);
		rd(A_LVDC);
		chk(d, 32'h1);
		chk(irq, 32'h0);
		f = mk(1'h0, CLS_CCM, 3'h3);
		f.period_zero = 1'h1;
		fr(f, V_DROP, 1'h1);
		@(posedge aclk);
		#1;
		chk(irq, 32'h1);
		rb(A_LAST, L_ZERO, 1'h1);
		wr(A_STKY, 32'h2);
		rb(A_STKY, S_ZERO, 1'h0);
		chk(irq, 32'h0);
		fr(f, V_DROP, 1'h1);
		rb(A_STKY, S_ZERO, 1'h0);
		fr(mk(1'h0, CLS_CCM, 3'h3), V_OAM, 1'h0);
		rb(A_STKY, S_ZERO, 1'h1);
	endtask
	task automatic t_dmac;
		eov_frame_t f;
		logic uc, mc, bad;
		wr(A_EXTR, 32'h8);
		for (int m = 0; m < 4; m++) begin
			wr(A_CTRL, 32'(m) << 4);
			for (int k = 0; k < 3; k++) begin
				uc = (k == 1);
				mc = (k == 0);
				bad = (m == 1 && !uc) || (m == 2 && !mc) || (m == 3 && !uc && !mc);
				f = mk(1'h0, CLS_OTHER, 3'h0);
				f.dmac_uc_ok = uc;
				f.dmac_mc_ok = mc;
				fr(f, bad ? V_DROP : V_OAM, bad);
			end
		end
		rb(A_STKY, S_DMAC, 1'h1);
	endtask
	task automatic t_vers;
		eov_frame_t f;
		wr(A_CTRL, 32'h40);
		wr(A_EXTR, 32'h10);
		f = mk(1'h0, CLS_OTHER, 3'h0);
		fr(f, V_OAM, 1'h0);
		f.version = 2'h1;
		fr(f, V_DROP, 1'h1);
		rb(A_STKY, S_VERS, 1'h1);
		for (int c = 2; c < 5; c++) begin
			f.cls = eov_cls_t'(c);
			fr(f, V_OAM, 1'h0);
		end
		fr(mk(1'h0, CLS_SYN, 3'h0), V_SYN, 1'h0);
		wr(A_VERS, 32'h0400_0000);
		f = mk(1'h0, CLS_OTHER, 3'h0);
		fr(f, V_DROP, 1'h1);
		f.version = 2'h2;
		fr(f, V_OAM, 1'h0);
		wr(A_CTRL, 32'h0);
		f.version = 2'h3;
		fr(f, V_OAM, 1'h0);
	endtask
	task automatic t_ids;
		eov_frame_t f;
		wr(A_IENA, 32'h0);
		wr(A_PEER, 32'h155);
		for (int i = 0; i < GID_WORDS; i++)
			wr(A_GID + 7'(4 * i), (i == 0) ? 32'ha5 : 32'h0);
		wr(A_EXTR, 32'h60);
		wr(A_CTRL, 32'h700);
		f = mk(1'h0, CLS_CCM, 3'h0);
		f.group_id = 384'ha5;
		f.mep_id = 13'h155;
		fr(f, V_OAM, 1'h0);
		f.group_id[383] = 1'h1;
		fr(f, V_DROP, 1'h1);
		rb(A_LAST, L_GID, 1'h1);
		rb(A_STKY, S_GID, 1'h1);
		rd(A_GIDC);
		chk(d, 32'h1);
		chk(irq, 32'h0);
		wr(A_IENA, 32'h4);
		rd(A_GIDC);
		chk(irq, 32'h1);
		f.group_id = 384'ha5;
		f.mep_id = 13'h154;
		fr(f, V_DROP, 1'h1);
		rb(A_LAST, L_EID, 1'h1);
		rb(A_STKY, S_EID, 1'h1);
		rb(A_LAST, L_GID, 1'h0);
		rd(A_EIDC);
		chk(d, 32'h1);
		wr(A_CTRL, 32'h500);
		fr(f, V_OAM, 1'h0);
	endtask
	// ****************************************
	// clock, reset and main sequence
	// ****************************************
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		aresetn = 1'h0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
		{arvalid, rready} = '0;
		wstrb = 4'hf;
		n_fail = 0;
		check_count = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_bypass();
		t_tx();
		t_level();
		t_dmac();
		t_vers();
		t_ids();
		finish_test();
	end
endmodule
`default_nettype wire
